//--- hw/ufl_pkg.sv
package ufl_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // fifo geometry
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned PTR_W = 4;
  localparam int unsigned CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;

  //////////////////////////////////////////////////////////////////////////////
  // register offsets on the host address lines
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_INT_EN = 3'h1;
  localparam logic [2:0] OFS_IDENT = 3'h2;
  localparam logic [2:0] OFS_FMT = 3'h3;
  localparam logic [2:0] OFS_LSR = 3'h5;
  localparam logic [2:0] OFS_MSR = 3'h6;

  //////////////////////////////////////////////////////////////////////////////
  // fifo_control bit positions
  localparam int unsigned FC_EN = 0;
  localparam int unsigned FC_RX_FLUSH = 1;
  localparam int unsigned FC_TX_FLUSH = 2;
  localparam int unsigned FC_TRIG_LO = 6;
  localparam int unsigned FC_TRIG_HI = 7;

  // receive trigger levels in bytes
  localparam logic [CNT_W-1:0] TRIG_1 = 5'h01;
  localparam logic [CNT_W-1:0] TRIG_4 = 5'h04;
  localparam logic [CNT_W-1:0] TRIG_8 = 5'h08;
  localparam logic [CNT_W-1:0] TRIG_14 = 5'h0E;

  //////////////////////////////////////////////////////////////////////////////
  // interrupt_enable bit positions and reset
  localparam int unsigned IE_RDA = 0;
  localparam int unsigned IE_THRE = 1;
  localparam int unsigned IE_LS = 2;
  localparam int unsigned IE_MS = 3;
  localparam logic [3:0] INT_EN_RST = 4'h0;

  // interrupt_ident source codes for bits 3..1
  localparam logic [2:0] ID_LS = 3'h3;
  localparam logic [2:0] ID_RDA = 3'h2;
  localparam logic [2:0] ID_TMO = 3'h6;
  localparam logic [2:0] ID_THRE = 3'h1;
  localparam logic [2:0] ID_MODEM = 3'h0;

  //////////////////////////////////////////////////////////////////////////////
  // line format and character timing
  localparam logic [7:0] FMT_RST = 8'h00;
  localparam logic [3:0] WLEN_BASE = 4'h5;
  localparam logic [3:0] START_BITS = 4'h1;
  localparam logic [5:0] TIMEOUT_CHARS = 6'h04;
  // stop length in half bit times
  localparam logic [2:0] STOP_HALF_1 = 3'h2;
  localparam logic [2:0] STOP_HALF_1_5 = 3'h3;
  localparam logic [2:0] STOP_HALF_2 = 3'h4;

  typedef struct packed {
    logic divisor_latch_access;
    logic brk;
    logic stick;
    logic even;
    logic par_en;
    logic stop2;
    logic [1:0] wlen;
  } ufl_fmt_s;

  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ufl_bus_s;

endpackage

//--- hw/ufl_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module ufl_fifo
  import ufl_pkg::*;
(
  input wire logic clock_i, // system clock
  input wire logic arst_n_i, // async reset, low
  input wire logic flush_i, // discard all bytes
  input wire logic single_i, // holding register mode, depth 1
  input wire logic push_i, // write request
  input wire logic [7:0] data_i, // write data
  input wire logic pop_i, // read request
  output logic [7:0] head_o, // oldest byte, registered
  output logic [ufl_pkg::CNT_W-1:0] count_o, // bytes held
  output logic full_o, // no room
  output logic empty_o // nothing held
);
  import ufl_pkg::*;

  logic [7:0] mem_q [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d;
  logic [PTR_W-1:0] rd_ptr_q, rd_ptr_d;
  logic [CNT_W-1:0] count_q, count_d;
  logic [7:0] head_q, head_d;
  wire pop_ok = pop_i && !empty_o;
  wire push_ok = push_i && (!full_o || pop_ok);

  //////////////////////////////////////////////////////////////////////////////
  assign empty_o = (count_q == '0);
  assign full_o = single_i ? (count_q >= CNT_ONE) : (count_q >= CNT_FULL);
  assign count_o = count_q;
  assign head_o = head_q;

  assign rd_ptr_d = flush_i ? '0 : (pop_ok ? rd_ptr_q + 1'b1 : rd_ptr_q);
  assign wr_ptr_d = flush_i ? '0 : (push_ok ? wr_ptr_q + 1'b1 : wr_ptr_q);
  assign count_d = flush_i ? '0
                 : CNT_W'(count_q + {4'h0, push_ok} - {4'h0, pop_ok});
  // a byte pushed into the head slot bypasses the memory read
  assign head_d = flush_i ? 8'h00
                : ((push_ok && wr_ptr_q == rd_ptr_d) ? data_i
                : mem_q[rd_ptr_d]);

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_i)
  begin
    if (push_ok)
    begin
      mem_q[wr_ptr_q] <= data_i;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      head_q <= 8'h00;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
      head_q <= head_d;
    end
  end

endmodule
`default_nettype wire

//--- hw/ufl_core.sv
`timescale 1ns/1ps
`default_nettype none
module ufl_core
  import ufl_pkg::*;
(
  input wire logic clock_i, // system clock, 25 MHz
  input wire logic arst_n_i, // async reset, low
  input wire ufl_pkg::ufl_bus_s bus_i, // host bus request
  output logic [7:0] rdata_o, // host read data, held
  input wire logic [7:0] ext_rdata_i, // read data of outside registers
  output logic intr_o, // any enabled interrupt pending
  output logic fifo_mode_o, // fifos enabled
  output ufl_pkg::ufl_fmt_s fmt_o, // line format fields
  output logic [3:0] data_bits_o, // data bits per character
  output logic [2:0] tx_stop_half_o, // transmit stop, half bit times
  output logic [2:0] rx_stop_half_o, // receive stop checked, half bits
  input wire logic tx_pop_i, // transmit shifter takes a byte
  output logic [7:0] tx_data_o, // oldest transmit byte
  output logic tx_avail_o, // transmit byte waiting
  output logic tx_parity_o, // parity bit for tx_data_o
  input wire logic rx_push_i, // receive shifter delivers a byte
  input wire logic [7:0] rx_data_i, // received byte
  input wire logic rx_parity_i, // received parity bit
  output logic rx_parity_err_o, // parity mismatch on rx_data_i
  output logic rx_overrun_o, // byte lost, receive fifo full
  input wire logic bit_tick_i, // one pulse per bit time
  input wire logic lsr_int_i, // line status error pending
  input wire logic msr_int_i, // modem status change pending
  output logic lsr_read_o, // line status read pulse
  output logic msr_read_o // modem status read pulse
);
  import ufl_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // host access edges
  logic rd_act_q, wr_act_q;
  wire rd_lvl = bus_i.cs && bus_i.rd;
  wire wr_lvl = bus_i.cs && bus_i.wr;
  wire rd_go = rd_lvl && !rd_act_q;
  wire wr_go = wr_lvl && !wr_act_q;

  logic [7:0] fmt_q;
  ufl_fmt_s fmt;
  assign fmt = ufl_fmt_s'(fmt_q);

  // divisor latch access only steers offsets 0 and 1
  wire div_acc = fmt.divisor_latch_access;
  wire sel_data = (bus_i.addr == OFS_DATA) && !div_acc;
  wire sel_int_en = (bus_i.addr == OFS_INT_EN) && !div_acc;
  wire sel_ident = (bus_i.addr == OFS_IDENT);
  wire sel_fmt = (bus_i.addr == OFS_FMT);

  // offset 2 writes go to fifo_control, reads to interrupt_ident
  wire fctl_wr = wr_go && sel_ident;
  wire fctl_en = bus_i.wdata[FC_EN];
  wire thr_wr = wr_go && sel_data;
  wire rbr_rd = rd_go && sel_data;
  wire ident_rd = rd_go && sel_ident;

  assign lsr_read_o = rd_go && (bus_i.addr == OFS_LSR);
  assign msr_read_o = rd_go && (bus_i.addr == OFS_MSR);

  //////////////////////////////////////////////////////////////////////////////
  // fifo_control state; bit 3 and bits 5..4 are not stored
  logic fifo_en_q, fifo_en_d;
  logic [1:0] trig_q, trig_d;
  logic [3:0] int_en_q;

  assign fifo_en_d = fctl_wr ? fctl_en : fifo_en_q;
  // trigger only taken together with the enable bit
  assign trig_d = (fctl_wr && fctl_en)
                ? bus_i.wdata[FC_TRIG_HI:FC_TRIG_LO] : trig_q;
  // the ready pin mode bit is decoded by nothing
  // flush requests are pulses, never stored; offset 2 reads return interrupt_ident instead
  wire rx_flush = fctl_wr
                && (!fctl_en || bus_i.wdata[FC_RX_FLUSH]);
  wire tx_flush = fctl_wr
                && (!fctl_en || bus_i.wdata[FC_TX_FLUSH]);

  //////////////////////////////////////////////////////////////////////////////
  // fifos; outside fifo mode each is a one byte holding register
  logic [7:0] rx_head;
  logic [CNT_W-1:0] rx_count, tx_count;
  logic rx_full, rx_empty, tx_full, tx_empty;

  // the shifters sit outside, so a flush leaves them intact
  ufl_fifo u_tx_fifo (
    .clock_i (clock_i),
    .arst_n_i (arst_n_i),
    .flush_i (tx_flush),
    .single_i (!fifo_en_q),
    .push_i (thr_wr),
    .data_i (bus_i.wdata),
    .pop_i (tx_pop_i),
    .head_o (tx_data_o),
    .count_o (tx_count),
    .full_o (tx_full),
    .empty_o (tx_empty)
  );

  ufl_fifo u_rx_fifo (
    .clock_i (clock_i),
    .arst_n_i (arst_n_i),
    .flush_i (rx_flush),
    .single_i (!fifo_en_q),
    .push_i (rx_push_i),
    .data_i (rx_data_i),
    .pop_i (rbr_rd),
    .head_o (rx_head),
    .count_o (rx_count),
    .full_o (rx_full),
    .empty_o (rx_empty)
  );

  assign tx_avail_o = !tx_empty;
  // no request pins; transfers happen only by host register access
  assign rx_overrun_o = rx_push_i && rx_full && !rbr_rd;

  //////////////////////////////////////////////////////////////////////////////
  // line format decode
  assign fmt_o = fmt;
  assign fifo_mode_o = fifo_en_q;
  // data bits only; start, parity and stop are separate
  assign data_bits_o = WLEN_BASE + {2'b00, fmt.wlen};
  assign tx_stop_half_o = !fmt.stop2 ? STOP_HALF_1
                        : ((fmt.wlen == 2'b00) ? STOP_HALF_1_5
                        : STOP_HALF_2);
  assign rx_stop_half_o = STOP_HALF_1;

  function automatic logic par_bit(input logic [7:0] d, input ufl_fmt_s f);
    logic [7:0] mask;
    logic ones;
    mask = 8'hFF >> (2'd3 - f.wlen);
    ones = ^(d & mask);
    if (f.stick)
    begin
      par_bit = !f.even;
    end
    else
    begin
      // odd parity makes the total count odd, even makes it even
      par_bit = f.even ? ones : !ones;
    end
  endfunction

  // parity sits between last data bit and first stop bit
  assign tx_parity_o = fmt.par_en && par_bit(tx_data_o, fmt);
  assign rx_parity_err_o = fmt.par_en
                         && (rx_parity_i != par_bit(rx_data_i, fmt));

  //////////////////////////////////////////////////////////////////////////////
  // character timeout, counted in bit times of the current frame
  logic [5:0] tmo_cnt_q, tmo_cnt_d;
  logic tmo_q, tmo_d;
  wire [3:0] frame_bits = START_BITS + data_bits_o + {3'b000, fmt.par_en}
                        + (fmt.stop2 ? 4'h2 : 4'h1);
  wire [5:0] tmo_limit = 6'({2'b00, frame_bits} * TIMEOUT_CHARS);
  wire rx_activity = rx_push_i || rbr_rd || rx_flush;
  wire tmo_idle = !fifo_en_q || rx_empty || rx_activity;
  wire tmo_hit = bit_tick_i && (tmo_cnt_q == tmo_limit - 6'h01);

  assign tmo_cnt_d = tmo_idle ? 6'h00
                   : ((bit_tick_i && !tmo_hit) ? tmo_cnt_q + 6'h01
                   : tmo_cnt_q);
  // cleared by a buffer read or fresh traffic, set only while tmo_idle is low
  assign tmo_d = tmo_idle ? 1'b0 : (tmo_hit || tmo_q);

  //////////////////////////////////////////////////////////////////////////////
  // interrupt sources and ranking
  logic [CNT_W-1:0] trig_lvl;
  always_comb
  begin
    case (trig_q)
      2'b00: trig_lvl = TRIG_1;
      2'b01: trig_lvl = TRIG_4;
      2'b10: trig_lvl = TRIG_8;
      default: trig_lvl = TRIG_14;
    endcase
  end

  logic thre_q, thre_d;
  logic tx_empty_q, ie_thre_q;
  logic [2:0] ident_id;
  logic [7:0] ident_byte;

  // received data drops by itself below threshold
  wire rda = fifo_en_q ? (rx_count >= trig_lvl) : !rx_empty;
  wire act_ls = lsr_int_i && int_en_q[IE_LS];
  wire act_rda = rda && int_en_q[IE_RDA];
  wire act_tmo = tmo_q && int_en_q[IE_RDA];
  wire act_thre = thre_q && int_en_q[IE_THRE];
  wire act_ms = msr_int_i && int_en_q[IE_MS];
  wire any_act = act_ls || act_rda || act_tmo || act_thre || act_ms;

  assign ident_id = act_ls ? ID_LS
                  : act_rda ? ID_RDA
                  : act_tmo ? ID_TMO
                  : act_thre ? ID_THRE
                  : ID_MODEM;
  assign ident_byte = {fifo_en_q, fifo_en_q, 2'b00,
                       ident_id[2] && fifo_en_q, ident_id[1:0],
                       !any_act};

  // thre pends on the fifo going empty or the enable being raised while empty
  wire thre_set = (tx_empty && !tx_empty_q)
                || (tx_empty && int_en_q[IE_THRE] && !ie_thre_q);
  wire thre_clr = thr_wr
                || (ident_rd && any_act && ident_id == ID_THRE);
  // an arriving event wins over a clear in the same cycle
  assign thre_d = thre_set || (thre_q && !thre_clr);
  // line status and modem status clear outside on the read pulses

  assign intr_o = any_act;

  //////////////////////////////////////////////////////////////////////////////
  // read data, sampled at the start of the access and held throughout
  logic [7:0] rdata_q, rdata_d;
  wire [7:0] rd_mux = sel_data ? rx_head
                    : sel_int_en ? {4'h0, int_en_q}
                    : sel_ident ? ident_byte
                    : sel_fmt ? fmt_q
                    : ext_rdata_i;
  assign rdata_d = rd_go ? rd_mux : rdata_q;
  assign rdata_o = rdata_q;

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      rd_act_q <= rd_lvl;
      wr_act_q <= wr_lvl;
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      fifo_en_q <= 1'b0;
      trig_q <= 2'b00;
      int_en_q <= INT_EN_RST;
      fmt_q <= FMT_RST;
    end
    else
    begin
      fifo_en_q <= fifo_en_d;
      trig_q <= trig_d;
      if (wr_go && sel_int_en)
      begin
        int_en_q <= bus_i.wdata[3:0];
      end
      if (wr_go && sel_fmt)
      begin
        fmt_q <= bus_i.wdata;
      end
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tmo_cnt_q <= 6'h00;
      tmo_q <= 1'b0;
      thre_q <= 1'b0;
      tx_empty_q <= 1'b1;
      ie_thre_q <= 1'b0;
    end
    else
    begin
      tmo_cnt_q <= tmo_cnt_d;
      tmo_q <= tmo_d;
      thre_q <= thre_d;
      tx_empty_q <= tx_empty;
      ie_thre_q <= int_en_q[IE_THRE];
    end
  end

endmodule
`default_nettype wire

//--- bench/ufl_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ufl_core_assertions
(
  input wire logic clock_i, // clock
  input wire logic arst_n_i, // reset
  input wire ufl_pkg::ufl_bus_s bus_i, // host bus
  input wire logic [7:0] rdata_o, // read data
  input wire logic intr_o, // pending
  input wire logic fifo_mode_o, // fifos on
  input wire ufl_pkg::ufl_fmt_s fmt_o, // format
  input wire logic [3:0] data_bits_o, // data bits
  input wire logic [2:0] tx_stop_half_o, // tx stop
  input wire logic [2:0] rx_stop_half_o, // rx stop
  input wire logic [7:0] tx_data_o, // tx head
  input wire logic tx_avail_o, // tx waiting
  input wire logic tx_parity_o, // tx parity
  input wire logic [7:0] rx_data_i, // rx byte
  input wire logic rx_parity_i, // rx parity
  input wire logic rx_parity_err_o // rx error
);
  import ufl_pkg::*;
  logic rd_q;
  logic wr_q;
  wire rd_go = bus_i.cs & bus_i.rd & ~rd_q;
  wire wr_go = bus_i.cs & bus_i.wr & ~wr_q;
  wire id_rd = rd_go && bus_i.addr == OFS_IDENT;
  wire id_wr = wr_go && bus_i.addr == OFS_IDENT;
  // only the bits of the word length take part in parity
  wire [7:0] mask = 8'hFF >> (2'h3 - fmt_o.wlen);
  wire tpar = ^(tx_data_o & mask);
  wire rpar = ^(rx_data_i & mask);
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end
    else
    begin
      rd_q <= bus_i.cs & bus_i.rd;
      wr_q <= bus_i.cs & bus_i.wr;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  //////////////////////////////////////////////////////////////////////////////
  property p_id_upper;
    id_rd |=> rdata_o[7:4] == {{2{$past(fifo_mode_o)}}, 2'b00}
      && ($past(fifo_mode_o) || !rdata_o[3]);
  endproperty
  a_id_upper: assert property (p_id_upper)
    else $error("ident upper bits");
  property p_id_pend;
    id_rd |=> rdata_o[0] == !$past(intr_o);
  endproperty
  a_id_pend: assert property (p_id_pend)
    else $error("ident pending bit");
  property p_id_hold;
    bus_i.cs && bus_i.rd && !rd_go && !$past(rd_go) |-> $stable(rdata_o);
  endproperty
  a_id_hold: assert property (p_id_hold)
    else $error("read data moved");
  property p_fifo_en;
    id_wr |=> fifo_mode_o == $past(bus_i.wdata[0]);
  endproperty
  a_fifo_en: assert property (p_fifo_en)
    else $error("fifo enable");
  property p_tx_flush;
    id_wr && (bus_i.wdata[2] || !bus_i.wdata[0]) |=> !tx_avail_o;
  endproperty
  a_tx_flush: assert property (p_tx_flush)
    else $error("tx not flushed");
  property p_fmt;
    wr_go && bus_i.addr == OFS_FMT |=> fmt_o == $past(bus_i.wdata);
  endproperty
  a_fmt: assert property (p_fmt)
    else $error("format write");
  property p_bits;
    data_bits_o == WLEN_BASE + {2'b00, fmt_o.wlen};
  endproperty
  a_bits: assert property (p_bits)
    else $error("data bits");
  property p_stop;
    tx_stop_half_o == (!fmt_o.stop2 ? STOP_HALF_1 :
      (fmt_o.wlen == 2'h0) ? STOP_HALF_1_5 : STOP_HALF_2);
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop length");
  property p_rx_stop;
    rx_stop_half_o == STOP_HALF_1;
  endproperty
  a_rx_stop: assert property (p_rx_stop)
    else $error("rx stop check");
  property p_tx_par;
    fmt_o.par_en |-> tx_parity_o == (fmt_o.stick ? !fmt_o.even :
      tpar ^ !fmt_o.even);
  endproperty
  a_tx_par: assert property (p_tx_par)
    else $error("tx parity");
  property p_rx_par;
    fmt_o.par_en |-> rx_parity_err_o ==
      (rx_parity_i ^ !fmt_o.even ^ (fmt_o.stick ? 1'b0 : rpar));
  endproperty
  a_rx_par: assert property (p_rx_par)
    else $error("rx parity check");
  c_timeout: cover property (id_rd ##1 rdata_o[3:0] == 4'hC);
  c_flush: cover property (id_wr && bus_i.wdata[2]);
  c_stick: cover property (fmt_o.par_en && fmt_o.stick);
endmodule
`default_nettype wire

//--- bench/ufl_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module ufl_line_model
(
  input wire logic clock_i, // clock
  input wire logic lsr_read_i, // line status read
  input wire logic msr_read_i, // modem status read
  output logic bit_tick_o, // baud tick
  output logic rx_push_o, // byte delivered
  output logic [7:0] rx_data_o, // byte
  output logic rx_parity_o, // parity bit
  output logic tx_pop_o, // shifter takes byte
  output logic [7:0] ext_rdata_o, // outside registers
  output logic lsr_int_o, // line status source
  output logic msr_int_o // modem source
);
  logic [1:0] div_q = 2'h0;
  // arbitrary content of the outside registers
  assign ext_rdata_o = 8'h5A;
  assign bit_tick_o = (div_q == 2'h3);
  initial
  begin
    rx_push_o = 1'b0;
    rx_data_o = 8'h00;
    rx_parity_o = 1'b0;
    tx_pop_o = 1'b0;
    lsr_int_o = 1'b0;
    msr_int_o = 1'b0;
  end
  always @(posedge clock_i)
  begin
    div_q <= #1 div_q + 2'h1;
    if (lsr_read_i)
      lsr_int_o <= #1 1'b0;
    if (msr_read_i)
      msr_int_o <= #1 1'b0;
  end
  task automatic push(input logic [7:0] d, input logic p);
    @(posedge clock_i);
    #1;
    rx_push_o = 1'b1;
    rx_data_o = d;
    rx_parity_o = p;
    @(posedge clock_i);
    #1;
    rx_push_o = 1'b0;
    rx_data_o = ~d;
    rx_parity_o = ~p;
  endtask
  task automatic pop();
    @(posedge clock_i);
    #1;
    tx_pop_o = 1'b1;
    @(posedge clock_i);
    #1;
    tx_pop_o = 1'b0;
  endtask
  task automatic raise(input logic ls, input logic ms);
    @(posedge clock_i);
    #1;
    lsr_int_o = ls;
    msr_int_o = ms;
  endtask
endmodule
`default_nettype wire

//--- bench/ufl_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ufl_core_bench;
  import ufl_pkg::*;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  ufl_bus_s bus_i = '0;
  logic [7:0] rdata_o, ext_rd, tx_data_o, rx_data;
  logic intr_o, fifo_mode_o, tx_avail_o, tx_parity_o, par_err, ovr;
  logic tick, push, rpar, pop, ls_int, ms_int, ls_rd, ms_rd;
  ufl_fmt_s fmt_o;
  logic [3:0] data_bits_o;
  logic [2:0] tx_stop_half_o, rx_stop_half_o;
  int n_errors = 0;
  int comparisons = 0;
  int trig[4] = '{1, 4, 8, 14};
  logic [7:0] pf[5] = '{8'h1B, 8'h0B, 8'h2B, 8'h3B, 8'h03};
  logic [7:0] pe[5] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00};
  always #20 clock_i = ~clock_i;
  ufl_core dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .ext_rdata_i(ext_rd), .intr_o(intr_o),
    .fifo_mode_o(fifo_mode_o), .fmt_o(fmt_o), .data_bits_o(data_bits_o),
    .tx_stop_half_o(tx_stop_half_o), .rx_stop_half_o(rx_stop_half_o),
    .tx_pop_i(pop), .tx_data_o(tx_data_o), .tx_avail_o(tx_avail_o),
    .tx_parity_o(tx_parity_o), .rx_push_i(push), .rx_data_i(rx_data),
    .rx_parity_i(rpar), .rx_parity_err_o(par_err), .rx_overrun_o(ovr),
    .bit_tick_i(tick), .lsr_int_i(ls_int), .msr_int_i(ms_int),
    .lsr_read_o(ls_rd), .msr_read_o(ms_rd));
  ufl_line_model u_line (.clock_i(clock_i), .lsr_read_i(ls_rd),
    .msr_read_i(ms_rd), .bit_tick_o(tick), .rx_push_o(push),
    .rx_data_o(rx_data), .rx_parity_o(rpar), .tx_pop_o(pop),
    .ext_rdata_o(ext_rd), .lsr_int_o(ls_int), .msr_int_o(ms_int));
  //////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string s, input logic [7:0] e,
                       input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  // one access: strobe held for the taking edge, dropped after
  task automatic acc(input logic r, input logic [2:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge clock_i);
    #1;
    bus_i = '{1'b1, r, !r, a, d};
    @(posedge clock_i);
    #1;
    q = rdata_o;
    bus_i = '0;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b0, a, d, q);
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] e,
                      input string s);
    logic [7:0] q;
    acc(1'b1, a, 8'h00, q);
    check(s, e, q);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clock_i);
    n_errors++;
    tally_and_finish();
  end
  initial
  begin
    repeat (6) @(posedge clock_i);
    #1;
    arst_n_i = 1'b1;
    rchk(OFS_IDENT, 8'h01, "ident");
    rchk(OFS_FMT, 8'h00, "format");
    check("fifo mode", 8'h00, {7'h0, fifo_mode_o});
    $display("reset test done");
    for (int w = 0; w < 4; w++)
    begin
      wr(OFS_FMT, 8'h04 | 8'(w));
      rchk(OFS_FMT, 8'h04 | 8'(w), "format");
      check("bits", 8'(5 + w), {4'h0, data_bits_o});
      check("stop", (w == 0) ? 8'h03 : 8'h04, 8'(tx_stop_half_o));
    end
    $display("format test done");
    wr(OFS_FMT, 8'h03);
    wr(OFS_INT_EN, 8'h01);
    for (int t = 0; t < 4; t++)
    begin
      wr(OFS_IDENT, {2'(t), 6'h03});
      for (int i = 1; i < trig[t]; i++)
        u_line.push(8'h10 + 8'(i), 1'b0);
      rchk(OFS_IDENT, 8'hC1, "below trigger");
      u_line.push(8'h10, 1'b0);
      rchk(OFS_IDENT, 8'hC4, "at trigger");
    end
    rchk(OFS_DATA, 8'h11, "rx head");
    rchk(OFS_IDENT, 8'hC1, "under trigger");
    $display("trigger test done");
    wr(OFS_IDENT, 8'hC3);
    u_line.push(8'h42, 1'b0);
    repeat (150) @(posedge clock_i);
    rchk(OFS_IDENT, 8'hC1, "before timeout");
    repeat (40) @(posedge clock_i);
    rchk(OFS_IDENT, 8'hCC, "timeout");
    rchk(OFS_DATA, 8'h42, "rx byte");
    rchk(OFS_IDENT, 8'hC1, "timeout gone");
    $display("timeout test done");
    wr(OFS_IDENT, 8'h07);
    u_line.raise(1'b1, 1'b1);
    wr(OFS_INT_EN, 8'h0F);
    u_line.push(8'h33, 1'b0);
    rchk(OFS_IDENT, 8'hC6, "line status");
    rchk(OFS_LSR, 8'h5A, "status reg");
    rchk(OFS_IDENT, 8'hC4, "data");
    rchk(OFS_DATA, 8'h33, "rx byte");
    rchk(OFS_IDENT, 8'hC2, "thr empty");
    rchk(OFS_IDENT, 8'hC0, "modem");
    rchk(OFS_MSR, 8'h5A, "modem reg");
    rchk(OFS_IDENT, 8'hC1, "none");
    // a long ident read keeps the value taken at its first edge
    fork
      begin
        @(posedge clock_i);
        #1;
        bus_i = '{1'b1, 1'b1, 1'b0, OFS_IDENT, 8'h00};
        repeat (4) @(posedge clock_i);
        #1;
        check("ident held", 8'hC1, rdata_o);
        bus_i = '0;
      end
      u_line.push(8'h44, 1'b0);
    join
    rchk(OFS_IDENT, 8'hC4, "after hold");
    rchk(OFS_DATA, 8'h44, "rx byte");
    $display("priority test done");
    wr(OFS_INT_EN, 8'h00);
    wr(OFS_DATA, 8'hA1);
    wr(OFS_DATA, 8'hB2);
    check("tx head", 8'hA1, tx_data_o);
    u_line.pop();
    check("tx next", 8'hB2, tx_data_o);
    foreach (pf[k])
    begin
      wr(OFS_FMT, pf[k]);
      check("tx parity", pe[k], {7'h0, tx_parity_o});
    end
    wr(OFS_IDENT, 8'h0D);
    check("tx flushed", 8'h00, {7'h0, tx_avail_o});
    rchk(OFS_IDENT, 8'hC1, "ident");
    wr(OFS_DATA, 8'hC5);
    wr(OFS_IDENT, 8'h00);
    check("tx disabled", 8'h00, {7'h0, tx_avail_o});
    rchk(OFS_IDENT, 8'h01, "ident off");
    // outside fifo mode a second byte finds the holding register full
    u_line.push(8'h61, 1'b0);
    fork
      u_line.push(8'h62, 1'b0);
      begin
        @(posedge clock_i);
        #2;
        check("overrun", 8'h01, {7'h0, ovr});
      end
    join
    rchk(OFS_DATA, 8'h61, "held byte");
    $display("transmit test done");
    wr(OFS_FMT, 8'h83);
    rchk(OFS_DATA, 8'h5A, "divisor low");
    rchk(OFS_INT_EN, 8'h5A, "divisor high");
    rchk(3'h7, 8'h5A, "scratch");
    wr(OFS_FMT, 8'h03);
    rchk(OFS_INT_EN, 8'h00, "enables");
    $display("divisor test done");
    tally_and_finish();
  end
endmodule
bind ufl_core ufl_core_assertions u_chk (.clock_i(clock_i),
  .arst_n_i(arst_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .intr_o(intr_o), .fifo_mode_o(fifo_mode_o), .fmt_o(fmt_o),
  .data_bits_o(data_bits_o), .tx_stop_half_o(tx_stop_half_o),
  .rx_stop_half_o(rx_stop_half_o), .tx_data_o(tx_data_o),
  .tx_avail_o(tx_avail_o), .tx_parity_o(tx_parity_o),
  .rx_data_i(rx_data_i), .rx_parity_i(rx_parity_i),
  .rx_parity_err_o(rx_parity_err_o));
`default_nettype wire
